// file: core/mmes_pkg.sv
// Constants and types for the mesh-to-memory event selection block.
// Assumes a single 100 MHz clock and a plain register port with 8-bit byte addresses.
package mmes_pkg;

  localparam int NUM_CTRS        = 6;
  localparam int RESTRICTED_CTRS = 4;
  localparam int CNT_W           = 32;
  localparam int DATA_W          = 32;
  localparam int ADDR_W          = 8;
  localparam int FILL_W          = 6;
  localparam int INC_W           = FILL_W;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: selector and count of counter i at base + i * stride
  localparam logic [ADDR_W-1:0] SEL_BASE   = 8'h00;
  localparam logic [ADDR_W-1:0] CNT_BASE   = 8'h04;
  localparam logic [ADDR_W-1:0] CTR_STRIDE = 8'h08;

  localparam int CODE_LSB  = 0;
  localparam int CODE_MSB  = 7;
  localparam int UMASK_LSB = 8;
  localparam int UMASK_MSB = 15;
  localparam int EN_BIT    = 22;

  localparam logic [DATA_W-1:0] SEL_WMASK = 32'h0040_FFFF;
  localparam logic [DATA_W-1:0] SEL_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RD_IDLE   = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Event codes
  localparam logic [7:0] CLOCKTICK_CODE                = 8'h00;
  localparam logic [7:0] INGRESS_MC_SKIP_COUNT_CODE    = 8'h21;
  localparam logic [7:0] EGRESS_MC_SKIP_COUNT_CODE     = 8'h22;
  localparam logic [7:0] CORE_SHORTCUT_DISABLED_CODE   = 8'h24;
  localparam logic [7:0] CORE_SHORTCUT_OVERRIDE_CODE   = 8'h25;
  localparam logic [7:0] LINK_SHORTCUT_DISABLED_CODE   = 8'h27;
  localparam logic [7:0] LINK_SHORTCUT_CREDIT_CODE     = 8'h28;
  localparam logic [7:0] LINK_SHORTCUT_OVERRIDE_CODE   = 8'h29;
  localparam logic [7:0] DIR_HIT_CODE                  = 8'h2a;
  localparam logic [7:0] DIR_MISS_CODE                 = 8'h2b;
  localparam logic [7:0] DIR_LOOKUP_COUNT_CODE         = 8'h2d;
  localparam logic [7:0] MC_READ_COUNT_CODE            = 8'h37;
  localparam logic [7:0] MC_WRITE_COUNT_CODE           = 8'h38;
  localparam logic [7:0] HEADER_MATCH_COUNT_CODE       = 8'h4c;
  localparam logic [7:0] MIRROR_QUEUE_INSERT_CODE      = 8'h64;
  localparam logic [7:0] MIRROR_QUEUE_FILL_LEVEL_CODE  = 8'h65;

  // Memory target encoding of a read or write
  localparam logic [1:0] TGT_DDR_MEM   = 2'h0;
  localparam logic [1:0] TGT_DDR_CACHE = 2'h1;
  localparam logic [1:0] TGT_PERSIST   = 2'h2;

  localparam int RD_PERSIST_BIT = 5;

  // Internal conditions, captured once per clock
  typedef struct packed {
    logic              egress_taken;
    logic              egress_not_taken;
    logic              ingress_taken;
    logic              ingress_not_taken;
    logic              core_disabled;
    logic              core_override;
    logic              link_disabled;
    logic              link_credit_override;
    logic              link_override;
    logic [7:0]        dir_hit;
    logic [7:0]        dir_miss;
    logic [3:0]        dir_lookup;
    logic              rd_valid;
    logic              rd_critical;
    logic              rd_full;
    logic              rd_tgen;
    logic              rd_scrub;
    logic [1:0]        rd_target;
    logic              wr_valid;
    logic              wr_critical;
    logic              wr_partial;
    logic              wr_scrub;
    logic [1:0]        wr_target;
    logic              mirror_insert;
    logic [FILL_W-1:0] mirror_fill;
    logic              match_mesh;
    logic              match_mc;
  } mmes_cond_t;

endpackage

// file: core/mmes_ctr_if.sv
// Control and count of one event counter between the selector and the accumulator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface mmes_ctr_if;
  logic                       load;
  logic [mmes_pkg::CNT_W-1:0] load_value;
  logic [mmes_pkg::INC_W-1:0] inc;
  logic [mmes_pkg::CNT_W-1:0] count;

  modport ctl (output load, output load_value, output inc, input count);
  modport acc (input load, input load_value, input inc, output count);
endinterface

// file: core/mmes_ctr_acc.sv
// One event counter: software load, otherwise adds the increment each clock.
// Assumes the increment is already gated by enable and selection.
`timescale 1ns/10ps
module mmes_ctr_acc (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  mmes_ctr_if.acc   ctr
);
  logic [mmes_pkg::CNT_W-1:0] count_reg;

  // Software load wins so a preset is never disturbed by a same-cycle event
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= mmes_pkg::CNT_RESET;
    end else if (ctr.load) begin
      count_reg <= ctr.load_value;
    end else begin
      count_reg <= count_reg + mmes_pkg::CNT_W'(ctr.inc);
    end
  end

  assign ctr.count = count_reg;
endmodule

// file: core/mmes_event_select.sv
// Event selection and unit-mask decode for the mesh-to-memory agent counters.
// Assumes condition inputs come from logic on ref_clk_in, the agent's uncore clock.
//
// Contract
// - Code 0x22 counts egress bypass: mask bit 0 taken, bit 1 not taken.
// - Code 0x21 counts ingress bypass, taken/not taken, counters 0-3 only.
// - Code 0x00 counts every uncore clock cycle.
// - Code 0x24 counts cycles core shortcut disabled by directory, counters 0-3.
// - Code 0x25 counts reads with core shortcut overridden, counters 0-3.
// - Codes 0x27, 0x28, 0x29 count link shortcut disabled, credit, overridden.
// - Code 0x2a counts directory hits; bits 0-3 dirty, 4-7 clean I/S/L/A.
// - Code 0x2b counts directory misses with the same eight-bit encoding.
// - Code 0x2d counts lookups: any, I, S, A; counters 0-3 only.
// - Code 0x37 counts memory reads by priority, target and traffic generator, counters 0-3 only.
// - Code 0x38 counts memory writes by priority, size and target, counters 0-3 only.
// - Scrub reads and writes are never counted.
// - Persistent writes count full and partial; persistent reads full only.
// - Code 0x64 counts mirror queue inserts, 0x65 adds mirror queue occupancy.
// - Code 0x4c counts header matches: bit 0 mesh, bit 1 memory controller.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
module mmes_event_select (
  input  wire logic                          ref_clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic [mmes_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [mmes_pkg::DATA_W-1:0]   reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic      [mmes_pkg::DATA_W-1:0]   reg_rdata_out,
  input  wire logic                          egress_skip_taken_in,
  input  wire logic                          egress_skip_not_taken_in,
  input  wire logic                          ingress_skip_taken_in,
  input  wire logic                          ingress_skip_not_taken_in,
  input  wire logic                          core_shortcut_disabled_in,
  input  wire logic                          core_shortcut_override_in,
  input  wire logic                          link_shortcut_disabled_in,
  input  wire logic                          link_shortcut_credit_in,
  input  wire logic                          link_shortcut_override_in,
  input  wire logic [7:0]                    dir_hit_in,
  input  wire logic [7:0]                    dir_miss_in,
  input  wire logic [3:0]                    dir_lookup_in,
  input  wire logic                          mc_rd_valid_in,
  input  wire logic                          mc_rd_critical_in,
  input  wire logic                          mc_rd_full_in,
  input  wire logic                          mc_rd_traffic_generator_in,
  input  wire logic                          mc_rd_scrub_in,
  input  wire logic [1:0]                    mc_rd_target_in,
  input  wire logic                          mc_wr_valid_in,
  input  wire logic                          mc_wr_critical_in,
  input  wire logic                          mc_wr_partial_in,
  input  wire logic                          mc_wr_scrub_in,
  input  wire logic [1:0]                    mc_wr_target_in,
  input  wire logic                          mirror_queue_insert_in,
  input  wire logic [mmes_pkg::FILL_W-1:0]   mirror_queue_fill_level_in,
  input  wire logic                          header_match_mesh_in,
  input  wire logic                          header_match_mc_in
);
  localparam int N = mmes_pkg::NUM_CTRS;

  mmes_pkg::mmes_cond_t       cond_reg;
  logic [mmes_pkg::DATA_W-1:0] sel_reg [N];
  logic [mmes_pkg::DATA_W-1:0] rd_data_reg;
  logic [mmes_pkg::DATA_W-1:0] rd_mux;
  logic [mmes_pkg::CNT_W-1:0]  cnt_val [N];
  logic [N-1:0]                sel_hit;
  logic [N-1:0]                cnt_hit;
  logic [6:0]                  rd_kind;
  logic [7:0]                  wr_kind;
  logic                        rd_ok;
  logic                        wr_ok;

  mmes_ctr_if ctr_if [N] ();

  ////////////////////////////////////////////////////////////////////////////
  // Condition capture, one stage to keep the decode off the source timing path
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cond_reg <= '0;
    end else begin
      cond_reg.egress_taken         <= egress_skip_taken_in;
      cond_reg.egress_not_taken     <= egress_skip_not_taken_in;
      cond_reg.ingress_taken        <= ingress_skip_taken_in;
      cond_reg.ingress_not_taken    <= ingress_skip_not_taken_in;
      cond_reg.core_disabled        <= core_shortcut_disabled_in;
      cond_reg.core_override        <= core_shortcut_override_in;
      cond_reg.link_disabled        <= link_shortcut_disabled_in;
      cond_reg.link_credit_override <= link_shortcut_credit_in;
      cond_reg.link_override        <= link_shortcut_override_in;
      cond_reg.dir_hit              <= dir_hit_in;
      cond_reg.dir_miss             <= dir_miss_in;
      cond_reg.dir_lookup           <= dir_lookup_in;
      cond_reg.rd_valid             <= mc_rd_valid_in;
      cond_reg.rd_critical          <= mc_rd_critical_in;
      cond_reg.rd_full              <= mc_rd_full_in;
      cond_reg.rd_tgen              <= mc_rd_traffic_generator_in;
      cond_reg.rd_scrub             <= mc_rd_scrub_in;
      cond_reg.rd_target            <= mc_rd_target_in;
      cond_reg.wr_valid             <= mc_wr_valid_in;
      cond_reg.wr_critical          <= mc_wr_critical_in;
      cond_reg.wr_partial           <= mc_wr_partial_in;
      cond_reg.wr_scrub             <= mc_wr_scrub_in;
      cond_reg.wr_target            <= mc_wr_target_in;
      cond_reg.mirror_insert        <= mirror_queue_insert_in;
      cond_reg.mirror_fill          <= mirror_queue_fill_level_in;
      cond_reg.match_mesh           <= header_match_mesh_in;
      cond_reg.match_mc             <= header_match_mc_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read and write classes shared by every counter
  assign rd_ok = cond_reg.rd_valid & ~cond_reg.rd_scrub;
  assign wr_ok = cond_reg.wr_valid & ~cond_reg.wr_scrub;

  // Persistent reads count full lines only
  assign rd_kind = {cond_reg.rd_tgen,
                    (cond_reg.rd_target == mmes_pkg::TGT_PERSIST) & cond_reg.rd_full,
                    cond_reg.rd_target == mmes_pkg::TGT_DDR_CACHE,
                    cond_reg.rd_target == mmes_pkg::TGT_DDR_MEM,
                    1'b1,
                    cond_reg.rd_critical,
                    ~cond_reg.rd_critical};

  // Persistent writes count whatever the size
  assign wr_kind = {cond_reg.wr_target == mmes_pkg::TGT_PERSIST,
                    cond_reg.wr_target == mmes_pkg::TGT_DDR_CACHE,
                    cond_reg.wr_target == mmes_pkg::TGT_DDR_MEM,
                    1'b1,
                    cond_reg.wr_critical & cond_reg.wr_partial,
                    cond_reg.wr_critical & ~cond_reg.wr_partial,
                    ~cond_reg.wr_critical & cond_reg.wr_partial,
                    ~cond_reg.wr_critical & ~cond_reg.wr_partial};

  ////////////////////////////////////////////////////////////////////////////
  // Per-counter address decode, event decode and accumulator
  for (genvar i = 0; i < N; i++) begin : g_ctr
    // Restricted events simply never count on the upper counters
    localparam bit LOW = (i < mmes_pkg::RESTRICTED_CTRS);
    logic [7:0] code;
    logic [7:0] um;
    logic       hit;
    logic       occ;

    assign sel_hit[i] = reg_addr_in ==
                        mmes_pkg::ADDR_W'(mmes_pkg::SEL_BASE + i * mmes_pkg::CTR_STRIDE);
    assign cnt_hit[i] = reg_addr_in ==
                        mmes_pkg::ADDR_W'(mmes_pkg::CNT_BASE + i * mmes_pkg::CTR_STRIDE);
    assign code = sel_reg[i][mmes_pkg::CODE_MSB:mmes_pkg::CODE_LSB];
    assign um   = sel_reg[i][mmes_pkg::UMASK_MSB:mmes_pkg::UMASK_LSB];

    // Unit-mask bits OR together, so one cycle adds one at most, except code 0x65, which adds the mirror queue fill level
    always_comb begin
      hit = 1'b0;
      occ = 1'b0;
      case (code)
        mmes_pkg::CLOCKTICK_CODE:
          hit = 1'b1;
        mmes_pkg::EGRESS_MC_SKIP_COUNT_CODE:
          hit = |(um[1:0] & {cond_reg.egress_not_taken, cond_reg.egress_taken});
        mmes_pkg::INGRESS_MC_SKIP_COUNT_CODE:
          hit = LOW & |(um[1:0] & {cond_reg.ingress_not_taken,
                                   cond_reg.ingress_taken});
        mmes_pkg::CORE_SHORTCUT_DISABLED_CODE:
          hit = LOW & cond_reg.core_disabled;
        mmes_pkg::CORE_SHORTCUT_OVERRIDE_CODE:
          hit = LOW & cond_reg.core_override;
        mmes_pkg::LINK_SHORTCUT_DISABLED_CODE:
          hit = cond_reg.link_disabled;
        mmes_pkg::LINK_SHORTCUT_CREDIT_CODE:
          hit = cond_reg.link_credit_override;
        mmes_pkg::LINK_SHORTCUT_OVERRIDE_CODE:
          hit = cond_reg.link_override;
        mmes_pkg::DIR_HIT_CODE:
          hit = |(um & cond_reg.dir_hit);
        mmes_pkg::DIR_MISS_CODE:
          hit = |(um & cond_reg.dir_miss);
        mmes_pkg::DIR_LOOKUP_COUNT_CODE:
          hit = LOW & |(um[3:0] & cond_reg.dir_lookup);
        mmes_pkg::MC_READ_COUNT_CODE:
          hit = LOW & rd_ok & |(um[6:0] & rd_kind);
        mmes_pkg::MC_WRITE_COUNT_CODE:
          hit = LOW & wr_ok & |(um & wr_kind);
        mmes_pkg::HEADER_MATCH_COUNT_CODE:
          hit = |(um[1:0] & {cond_reg.match_mc, cond_reg.match_mesh});
        mmes_pkg::MIRROR_QUEUE_INSERT_CODE:
          hit = cond_reg.mirror_insert;
        mmes_pkg::MIRROR_QUEUE_FILL_LEVEL_CODE:
          occ = 1'b1;
        default:
          hit = 1'b0;
      endcase
    end

    // Interface arrays only take constant indices, so counts are copied out here
    assign cnt_val[i]           = ctr_if[i].count;
    assign ctr_if[i].load       = reg_wr_in & cnt_hit[i];
    assign ctr_if[i].load_value = reg_wdata_in;
    assign ctr_if[i].inc        = !sel_reg[i][mmes_pkg::EN_BIT] ? '0 :
                                  occ ? cond_reg.mirror_fill :
                                  mmes_pkg::INC_W'(hit);

    mmes_ctr_acc u_acc (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .ctr        (ctr_if[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int k = 0; k < N; k++) begin
        sel_reg[k] <= mmes_pkg::SEL_RESET;
      end
    end else if (reg_wr_in) begin
      for (int k = 0; k < N; k++) begin
        if (sel_hit[k]) begin
          sel_reg[k] <= reg_wdata_in & mmes_pkg::SEL_WMASK;
        end
      end
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    rd_mux = mmes_pkg::RD_IDLE;
    for (int k = 0; k < N; k++) begin
      if (sel_hit[k]) begin
        rd_mux = sel_reg[k];
      end
      if (cnt_hit[k]) begin
        rd_mux = cnt_val[k];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_reg <= mmes_pkg::RD_IDLE;
    end else if (reg_rd_in) begin
      rd_data_reg <= rd_mux;
    end else begin
      rd_data_reg <= mmes_pkg::RD_IDLE;
    end
  end

  assign reg_rdata_out = rd_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on counter 0 and on the last, unrestricted-only counter
  logic [7:0]                 c0;
  logic [7:0]                 u0;
  logic                       lv0;
  logic [7:0]                 cl;
  logic                       lvl;
  logic [mmes_pkg::CNT_W-1:0] n0;
  logic [mmes_pkg::CNT_W-1:0] nl;

  assign c0  = g_ctr[0].code;
  assign u0  = g_ctr[0].um;
  assign lv0 = sel_reg[0][mmes_pkg::EN_BIT] & ~ctr_if[0].load;
  assign n0  = ctr_if[0].count;
  assign cl  = g_ctr[N-1].code;
  assign lvl = sel_reg[N-1][mmes_pkg::EN_BIT] & ~ctr_if[N-1].load;
  assign nl  = ctr_if[N-1].count;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_egress_bypass_step: assert property (
    lv0 && c0 == mmes_pkg::EGRESS_MC_SKIP_COUNT_CODE && u0[1] && cond_reg.egress_not_taken
    |=> n0 == $past(n0) + 1'b1) else $error("egress bypass not counted");
  chk_ingress_restricted: assert property (
    lvl && cl == mmes_pkg::INGRESS_MC_SKIP_COUNT_CODE |=> $stable(nl))
    else $error("ingress bypass counted on upper counter");
  chk_clocktick_run: assert property (
    (lv0 && c0 == mmes_pkg::CLOCKTICK_CODE)[*3] |=> n0 == $past(n0, 3) + 3'd3)
    else $error("clockticks missed");
  chk_core_disabled_step: assert property (
    lv0 && c0 == mmes_pkg::CORE_SHORTCUT_DISABLED_CODE && cond_reg.core_disabled
    |=> n0 == $past(n0) + 1'b1) else $error("core shortcut disable not counted");
  chk_core_override_upper: assert property (
    lvl && cl == mmes_pkg::CORE_SHORTCUT_OVERRIDE_CODE |=> $stable(nl))
    else $error("core override counted on upper counter");
  chk_link_group_step: assert property (
    lvl && ((cl == mmes_pkg::LINK_SHORTCUT_CREDIT_CODE && cond_reg.link_credit_override) ||
            (cl == mmes_pkg::LINK_SHORTCUT_OVERRIDE_CODE && cond_reg.link_override))
    |=> nl == $past(nl) + 1'b1) else $error("link shortcut event not counted");
  chk_dir_hit_step: assert property (
    lv0 && c0 == mmes_pkg::DIR_HIT_CODE && |(u0 & cond_reg.dir_hit)
    |=> n0 == $past(n0) + 1'b1) else $error("directory hit not counted");
  chk_dir_miss_quiet: assert property (
    lv0 && c0 == mmes_pkg::DIR_MISS_CODE && !(|(u0 & cond_reg.dir_miss)) |=> $stable(n0))
    else $error("directory miss counted without match");
  chk_lookup_state_i: assert property (
    lv0 && c0 == mmes_pkg::DIR_LOOKUP_COUNT_CODE && u0[1] && cond_reg.dir_lookup[1]
    |=> n0 == $past(n0) + 1'b1) else $error("lookup in I state not counted");
  chk_read_critical: assert property (
    lv0 && c0 == mmes_pkg::MC_READ_COUNT_CODE && u0[1] && rd_ok && cond_reg.rd_critical
    |=> n0 == $past(n0) + 1'b1) else $error("critical read not counted");
  chk_write_crit_part: assert property (
    lv0 && c0 == mmes_pkg::MC_WRITE_COUNT_CODE && u0[3] && wr_ok && cond_reg.wr_critical
    && cond_reg.wr_partial |=> n0 == $past(n0) + 1'b1) else $error("write not counted");
  chk_scrub_excluded: assert property (
    lv0 && ((c0 == mmes_pkg::MC_READ_COUNT_CODE && cond_reg.rd_scrub) ||
            (c0 == mmes_pkg::MC_WRITE_COUNT_CODE && cond_reg.wr_scrub))
    |=> $stable(n0)) else $error("scrub access counted");
  chk_persist_read_full: assert property (
    lv0 && c0 == mmes_pkg::MC_READ_COUNT_CODE && u0 == 8'(1 << mmes_pkg::RD_PERSIST_BIT)
    && !cond_reg.rd_full |=> $stable(n0)) else $error("partial persistent read counted");
  chk_mirror_fill_add: assert property (
    lv0 && c0 == mmes_pkg::MIRROR_QUEUE_FILL_LEVEL_CODE
    |=> n0 == $past(n0) + mmes_pkg::CNT_W'($past(cond_reg.mirror_fill)))
    else $error("mirror occupancy not added");
  chk_match_mc_step: assert property (
    lv0 && c0 == mmes_pkg::HEADER_MATCH_COUNT_CODE && u0[1] && cond_reg.match_mc
    |=> n0 == $past(n0) + 1'b1) else $error("header match not counted");
  chk_or_single_inc: assert property (
    lv0 && c0 == mmes_pkg::DIR_HIT_CODE && (&u0) && (&cond_reg.dir_hit)
    |=> n0 - $past(n0) == 32'h0000_0001) else $error("several mask bits added more than one");

  cov_clocktick_run: cover property ((lv0 && c0 == mmes_pkg::CLOCKTICK_CODE)[*4]);
  cov_restricted_try: cover property (lvl && cl == mmes_pkg::MC_READ_COUNT_CODE
                                      && rd_ok);
  cov_mirror_fill: cover property (lv0 && c0 == mmes_pkg::MIRROR_QUEUE_FILL_LEVEL_CODE
                                   && cond_reg.mirror_fill != '0);
  cov_count_readback: cover property (reg_rd_in && cnt_hit[0] ##1 reg_rdata_out != '0);
endmodule

// file: dv/mmes_event_select_test.sv
// Self-checking bench for the event selector: register port tasks and event sequences.
// Assumes the block sees one 100 MHz clock and its conditions are driven on that clock.
`timescale 1ns/10ps
module mmes_event_select_test;
  logic                 ref_clk_in;
  logic                 rst_n_in;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [7:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic [31:0]          reg_rdata;
  logic [31:0]          v0;
  logic [31:0]          v1;
  mmes_pkg::mmes_cond_t c;
  mmes_pkg::mmes_cond_t cv;
  int                   mismatches;
  int                   check_count;

  mmes_event_select u_mmes_event_select (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .egress_skip_taken_in(c.egress_taken), .egress_skip_not_taken_in(c.egress_not_taken),
    .ingress_skip_taken_in(c.ingress_taken), .ingress_skip_not_taken_in(c.ingress_not_taken),
    .core_shortcut_disabled_in(c.core_disabled), .core_shortcut_override_in(c.core_override),
    .link_shortcut_disabled_in(c.link_disabled), .link_shortcut_credit_in(c.link_credit_override),
    .link_shortcut_override_in(c.link_override), .dir_hit_in(c.dir_hit),
    .dir_miss_in(c.dir_miss), .dir_lookup_in(c.dir_lookup), .mc_rd_valid_in(c.rd_valid),
    .mc_rd_critical_in(c.rd_critical), .mc_rd_full_in(c.rd_full),
    .mc_rd_traffic_generator_in(c.rd_tgen), .mc_rd_scrub_in(c.rd_scrub),
    .mc_rd_target_in(c.rd_target), .mc_wr_valid_in(c.wr_valid),
    .mc_wr_critical_in(c.wr_critical), .mc_wr_partial_in(c.wr_partial),
    .mc_wr_scrub_in(c.wr_scrub), .mc_wr_target_in(c.wr_target),
    .mirror_queue_insert_in(c.mirror_insert), .mirror_queue_fill_level_in(c.mirror_fill),
    .header_match_mesh_in(c.match_mesh), .header_match_mc_in(c.match_mc));

////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Conditions in cv held for exactly three sampling edges, then the count is read
  task automatic ev(input int i, input logic [7:0] code, input logic [7:0] m, input int e);
    logic [31:0] got;
    wr(8'(8 * i), {16'h0040, m, code});
    wr(8'(8 * i + 4), '0);
    c <= cv;
    repeat (3) @(posedge ref_clk_in);
    c <= '0;
    repeat (3) @(posedge ref_clk_in);
    rd(8'(8 * i + 4), got);
    chk("event count", 32'(e), got);
    wr(8'(8 * i), '0);
    $display("test done: code %h mask %h counter %0d", code, m, i);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Fixed-length sequences only, so a hang can only come from the simulator itself
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
  initial begin
    {rst_n_in, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    c = '0;
    cv = '0;
    mismatches = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(8'h04, v0);
    chk("count reset", '0, v0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, v0);
    chk("selector bits", mmes_pkg::SEL_WMASK, v0);
    wr(8'h10, '0);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, v0);
    chk("unmapped read", '0, v0);
    wr(8'h00, 32'h0040_0000);
    rd(8'h04, v0);
    rd(8'h04, v1);
    chk("clockticks", 32'h0000_0002, v1 - v0);
    wr(8'h00, '0);
    cv.egress_taken = 1'b1;
    ev(0, 8'h22, 8'h01, 3);
    ev(0, 8'h22, 8'h02, 0);
    cv = '0;
    cv.ingress_not_taken = 1'b1;
    cv.core_disabled = 1'b1;
    ev(1, 8'h21, 8'h02, 3);
    ev(5, 8'h21, 8'h02, 0);
    ev(0, 8'h24, 8'h00, 3);
    ev(5, 8'h24, 8'h00, 0);
    ev(3, 8'h25, 8'h00, 0);
    cv = '0;
    cv.core_override = 1'b1;
    cv.link_disabled = 1'b1;
    cv.link_credit_override = 1'b1;
    ev(3, 8'h25, 8'h00, 3);
    ev(5, 8'h25, 8'h00, 0);
    ev(4, 8'h27, 8'h00, 3);
    ev(5, 8'h28, 8'h00, 3);
    ev(0, 8'h29, 8'h00, 0);
    cv = '0;
    cv.dir_hit = 8'hFF;
    cv.dir_miss = 8'h10;
    cv.dir_lookup = 4'h4;
    ev(0, 8'h2a, 8'hFF, 3);
    ev(2, 8'h2b, 8'h10, 3);
    ev(0, 8'h2b, 8'h01, 0);
    ev(3, 8'h2d, 8'h04, 3);
    ev(3, 8'h2d, 8'h02, 0);
    cv = '0;
    cv.rd_valid = 1'b1;
    cv.rd_critical = 1'b1;
    cv.rd_target = mmes_pkg::TGT_PERSIST;
    cv.wr_valid = 1'b1;
    cv.wr_partial = 1'b1;
    cv.wr_target = mmes_pkg::TGT_PERSIST;
    ev(0, 8'h37, 8'h02, 3);
    ev(5, 8'h37, 8'h04, 0);
    ev(0, 8'h37, 8'h01, 0);
    ev(0, 8'h37, 8'h20, 0);
    ev(1, 8'h38, 8'h80, 3);
    ev(1, 8'h38, 8'h02, 3);
    ev(1, 8'h38, 8'h01, 0);
    cv.rd_scrub = 1'b1;
    cv.wr_scrub = 1'b1;
    ev(0, 8'h37, 8'h04, 0);
    ev(1, 8'h38, 8'h10, 0);
    cv.rd_scrub = 1'b0;
    cv.wr_scrub = 1'b0;
    cv.rd_tgen = 1'b1;
    cv.rd_target = mmes_pkg::TGT_DDR_CACHE;
    cv.wr_critical = 1'b1;
    cv.wr_target = mmes_pkg::TGT_DDR_MEM;
    ev(0, 8'h37, 8'h50, 3);
    ev(0, 8'h37, 8'h08, 0);
    ev(0, 8'h38, 8'h28, 3);
    ev(1, 8'h38, 8'h44, 0);
    cv = '0;
    cv.mirror_insert = 1'b1;
    cv.mirror_fill = 6'h05;
    cv.match_mc = 1'b1;
    cv.egress_not_taken = 1'b1;
    cv.dir_lookup = 4'h2;
    ev(0, 8'h22, 8'h02, 3);
    ev(0, 8'h2d, 8'h02, 3);
    ev(2, 8'h64, 8'h00, 3);
    ev(0, 8'h65, 8'h00, 15);
    ev(0, 8'h4c, 8'h02, 3);
    ev(3, 8'h4c, 8'h01, 0);
    end_of_test();
  end
endmodule
